/* File: core/ppo_paired_pwm.sv */
// Notes on behaviour
// - duty settings are held with sixteen bits of resolution.
// - single-update mode uses one duty value for both half periods.
// - double-update mode reloads duty values at mid period for the second half.
// - duty is signed count of half-period high-side on-time; zero is fifty percent.
// - pair a duty drives a outputs, pair b duty drives b outputs.
// - timing unit applies dead time and its raw signals are active high.
// - each of four disable bits forces its output off while set.
// - disable writes apply at period start, and mid period in double-update.
// - reset clears all four disable bits.
// - crossover swaps high-side and low-side signals onto the other pin.
// - reset clears both crossover bits.
// - dead time stays in force after the crossover swap.
// - each period start raises the unit interrupt when its enable is set.
// - four units share one interrupt line with a global status register.
// - writing one to a global status bit clears it.
// - a read-only debug register returns each unit's four pin levels.
// - dead time moves both edges equally, keeping patterns symmetric.
// - per-output polarity selects active level and may change while running.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ppo_paired_pwm #(
  parameter int NU = ppo_pkg::NUM_UNITS,
  parameter int DW = ppo_pkg::DW
) (
  input  wire  logic                    clk_sys,
  input  wire  logic                    rst_b,
  input  wire  logic [ppo_pkg::AW-1:0]  reg_addr,
  input  wire  logic [DW-1:0]           reg_wdata,
  input  wire  logic                    reg_wr,
  input  wire  logic                    reg_rd,
  output logic       [DW-1:0]           reg_rdata,
  output logic       [NU-1:0]           high_side_a_out,
  output logic       [NU-1:0]           low_side_a_out,
  output logic       [NU-1:0]           high_side_b_out,
  output logic       [NU-1:0]           low_side_b_out,
  output logic                          period_irq
);
  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [DW-1:0] ctrl_r   [NU];
  logic [DW-1:0] ctrl_nxt [NU];
  logic [DW-1:0] per_r    [NU];
  logic [DW-1:0] per_nxt  [NU];
  logic [DW-1:0] dua_r    [NU];
  logic [DW-1:0] dua_nxt  [NU];
  logic [DW-1:0] dub_r    [NU];
  logic [DW-1:0] dub_nxt  [NU];
  logic [DW-1:0] dead_r   [NU];
  logic [DW-1:0] dead_nxt [NU];
  logic [DW-1:0] oc_r     [NU];
  logic [DW-1:0] oc_nxt   [NU];
  logic [DW-1:0] pol_r    [NU];
  logic [DW-1:0] pol_nxt  [NU];
  logic [NU-1:0] gstat_r, gstat_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic          irq_r, irq_nxt;
  logic [3:0]    pins_w   [NU];
  logic [NU-1:0] start_w, en_w, set_w, clr_w;
  logic          gstat_hit;

  // ****************************************************************
  // register map
  // ****************************************************************
  // addr[6] low: unit in addr[5:3], register in addr[2:0]
  //   0 control: irq enable bit 0, double update bit 1, run bit 2
  //   1 switching period count, halved per half period
  //   2, 3 duty counts of pair a and pair b, signed
  //   4 dead time count
  //   5 disables ah al bh bl in bits 3:0, crossover a bit 4, b bit 5
  //   6 polarity, one bit per pin, set for active high
  //   7 pin level debug, read only
  // address 0x40 is the shared interrupt status, bit per unit, write one to clear
  // unused bits and unmapped words read zero, so writes to them are dropped

  // true when the word address selects register rsel of unit u
  function automatic logic unit_hit(input logic [ppo_pkg::AW-1:0] a,
                                    input int u, input logic [2:0] rsel);
    unit_hit = (a[6] == 1'b0) && (a[5:3] == 3'(u)) && (a[2:0] == rsel);
  endfunction

  // ****************************************************************
  // timing units
  // ****************************************************************
  ppo_cfg_if cfg_if [NU] ();

  genvar gi;
  generate
    for (gi = 0; gi < NU; gi++) begin : g_unit
      assign cfg_if[gi].run    = ctrl_r[gi][ppo_pkg::CTRL_RUN_BIT];
      assign cfg_if[gi].dbl    = ctrl_r[gi][ppo_pkg::CTRL_DOUBLE_BIT];
      assign cfg_if[gi].period = per_r[gi];
      assign cfg_if[gi].duty_a = $signed(dua_r[gi]);
      assign cfg_if[gi].duty_b = $signed(dub_r[gi]);
      assign cfg_if[gi].dead   = dead_r[gi];
      assign cfg_if[gi].dis    = oc_r[gi][ppo_pkg::OUTCTL_DIS_LSB +: 4];
      assign cfg_if[gi].xov    = {oc_r[gi][ppo_pkg::OUTCTL_XOVB_BIT],
                                  oc_r[gi][ppo_pkg::OUTCTL_XOVA_BIT]};
      assign cfg_if[gi].pol    = pol_r[gi][3:0];
      assign pins_w[gi]        = cfg_if[gi].pins;
      assign start_w[gi]       = cfg_if[gi].start;
      assign en_w[gi]          = ctrl_r[gi][ppo_pkg::CTRL_IRQEN_BIT];

      // pins leave straight from the unit's output flops
      assign high_side_a_out[gi] = cfg_if[gi].pins[ppo_pkg::PIN_AH];
      assign low_side_a_out[gi]  = cfg_if[gi].pins[ppo_pkg::PIN_AL];
      assign high_side_b_out[gi] = cfg_if[gi].pins[ppo_pkg::PIN_BH];
      assign low_side_b_out[gi]  = cfg_if[gi].pins[ppo_pkg::PIN_BL];

      ppo_unit #(
        .DW (DW)
      ) u_unit (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cfg     (cfg_if[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // register writes and global status
  // ****************************************************************
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      ctrl_nxt[u] = ctrl_r[u];
      per_nxt[u]  = per_r[u];
      dua_nxt[u]  = dua_r[u];
      dub_nxt[u]  = dub_r[u];
      dead_nxt[u] = dead_r[u];
      oc_nxt[u]   = oc_r[u];
      pol_nxt[u]  = pol_r[u];
      if (reg_wr) begin
        if (unit_hit(reg_addr, u, ppo_pkg::REG_CTRL)) begin
          ctrl_nxt[u] = {13'h0000, reg_wdata[2:0]};
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_PERIOD)) begin
          per_nxt[u] = reg_wdata;
        end
        // duty writes land in the staging copy; the unit shadows them
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DUTY_A)) begin
          dua_nxt[u] = reg_wdata;
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DUTY_B)) begin
          dub_nxt[u] = reg_wdata;
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DEAD)) begin
          dead_nxt[u] = reg_wdata;
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_OUTCTL)) begin
          oc_nxt[u] = {10'h000, reg_wdata[5:0]};
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_POL)) begin
          pol_nxt[u] = {12'h000, reg_wdata[3:0]};
        end
      end
    end
    // a period start in the clearing cycle is kept: set wins over clear
    gstat_hit = reg_wr && (reg_addr == ppo_pkg::GSTAT_ADDR);
    set_w     = start_w & en_w;
    clr_w     = gstat_hit ? reg_wdata[NU-1:0] : {NU{1'b0}};
    gstat_nxt = (gstat_r & ~clr_w) | set_w;
    irq_nxt   = |gstat_nxt;
  end

  // ****************************************************************
  // register reads, data one cycle after the strobe
  // ****************************************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == ppo_pkg::GSTAT_ADDR) begin
        rdata_nxt = {{(DW-NU){1'b0}}, gstat_r};
      end
      for (int u = 0; u < NU; u++) begin
        if (unit_hit(reg_addr, u, ppo_pkg::REG_CTRL)) begin
          rdata_nxt = ctrl_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_PERIOD)) begin
          rdata_nxt = per_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DUTY_A)) begin
          rdata_nxt = dua_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DUTY_B)) begin
          rdata_nxt = dub_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DEAD)) begin
          rdata_nxt = dead_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_OUTCTL)) begin
          rdata_nxt = oc_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_POL)) begin
          rdata_nxt = pol_r[u];
        end
        if (unit_hit(reg_addr, u, ppo_pkg::REG_DEBUG)) begin
          rdata_nxt = {12'h000, pins_w[u]};
        end
      end
    end
  end

  // registers only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int u = 0; u < NU; u++) begin
        ctrl_r[u] <= ppo_pkg::REG_RST;
        per_r[u]  <= ppo_pkg::REG_RST;
        dua_r[u]  <= ppo_pkg::REG_RST;
        dub_r[u]  <= ppo_pkg::REG_RST;
        dead_r[u] <= ppo_pkg::REG_RST;
        oc_r[u]   <= ppo_pkg::REG_RST;
        pol_r[u]  <= ppo_pkg::REG_RST;
      end
      gstat_r <= {NU{1'b0}};
      rdata_r <= 16'h0000;
      irq_r   <= 1'b0;
    end else begin
      for (int u = 0; u < NU; u++) begin
        ctrl_r[u] <= ctrl_nxt[u];
        per_r[u]  <= per_nxt[u];
        dua_r[u]  <= dua_nxt[u];
        dub_r[u]  <= dub_nxt[u];
        dead_r[u] <= dead_nxt[u];
        oc_r[u]   <= oc_nxt[u];
        pol_r[u]  <= pol_nxt[u];
      end
      gstat_r <= gstat_nxt;
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign period_irq = irq_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_set_wins;
    @(posedge clk_sys) disable iff (!rst_b)
      (set_w != 0) |=> ((gstat_r & $past(set_w)) == $past(set_w)) && period_irq;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("period start lost");
  property p_w1c;
    @(posedge clk_sys) disable iff (!rst_b)
      (gstat_hit && ((reg_wdata[NU-1:0] & set_w) == 0))
        |=> ((gstat_r & $past(reg_wdata[NU-1:0])) == 0);
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared by one");
  property p_no_enable;
    @(posedge clk_sys) disable iff (!rst_b)
      (!gstat_hit && (set_w == 0)) |=> (gstat_r == $past(gstat_r));
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("status moved without cause");
  property p_irq_line;
    @(posedge clk_sys) disable iff (!rst_b)
      period_irq == (gstat_r != 0);
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line disagrees with status");
  property p_debug_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && unit_hit(reg_addr, 0, ppo_pkg::REG_DEBUG))
        |=> (reg_rdata == {12'h000, $past(pins_w[0])});
  endproperty
  a_debug_read: assert property (p_debug_read) else $error("debug read wrong");
  property p_dis_pin;
    @(posedge clk_sys) disable iff (!rst_b)
      (oc_r[0][ppo_pkg::PIN_BH] && ctrl_r[0][ppo_pkg::CTRL_RUN_BIT]) [*3]
        ##1 $stable(pol_r[0]) |-> ##[0:300] (high_side_b_out[0] == !pol_r[0][ppo_pkg::PIN_BH]);
  endproperty
  a_dis_pin: assert property (p_dis_pin) else $error("disabled output left on");
  property p_gstat_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && (reg_addr == ppo_pkg::GSTAT_ADDR))
        |=> (reg_rdata == {{(DW-NU){1'b0}}, $past(gstat_r)});
  endproperty
  a_gstat_read: assert property (p_gstat_read) else $error("status read wrong");
  property p_duty_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_rd && unit_hit(reg_addr, 0, ppo_pkg::REG_DUTY_A))
        |=> (reg_rdata == $past(dua_r[0]));
  endproperty
  a_duty_read: assert property (p_duty_read) else $error("duty read lost bits");
  property p_en_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_wr && unit_hit(reg_addr, 0, ppo_pkg::REG_CTRL))
        |=> (en_w[0] == $past(reg_wdata[ppo_pkg::CTRL_IRQEN_BIT]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("interrupt enable not taken");
  property p_dis_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_wr && unit_hit(reg_addr, 0, ppo_pkg::REG_OUTCTL))
        |=> (cfg_if[0].dis == $past(reg_wdata[3:0]));
  endproperty
  a_dis_write: assert property (p_dis_write) else $error("disable bits not taken");
  property p_xov_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_wr && unit_hit(reg_addr, 0, ppo_pkg::REG_OUTCTL))
        |=> (cfg_if[0].xov == $past(reg_wdata[5:4]));
  endproperty
  a_xov_write: assert property (p_xov_write) else $error("crossover bits not taken");
  property p_idle_pin;
    @(posedge clk_sys) disable iff (!rst_b)
      !ctrl_r[0][ppo_pkg::CTRL_RUN_BIT] ##1 !ctrl_r[0][ppo_pkg::CTRL_RUN_BIT]
        |=> (high_side_a_out[0] == !$past(pol_r[0][ppo_pkg::PIN_AH]));
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("stopped pin not at off level");
endmodule

/* File: core/ppo_pkg.sv */
// ****************************************************************
// paired pwm output stage: shared constants and types
// ****************************************************************
package ppo_pkg;
  localparam int NUM_UNITS = 4;        // units sharing one interrupt line
  localparam int DW        = 16;       // duty / period / dead time width
  localparam int AW        = 7;        // register word address width

  // per-unit register offsets, unit index in addr[5:3]
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_PERIOD = 3'h1;
  localparam logic [2:0] REG_DUTY_A = 3'h2;
  localparam logic [2:0] REG_DUTY_B = 3'h3;
  localparam logic [2:0] REG_DEAD   = 3'h4;
  localparam logic [2:0] REG_OUTCTL = 3'h5;
  localparam logic [2:0] REG_POL    = 3'h6;
  localparam logic [2:0] REG_DEBUG  = 3'h7;
  localparam logic [AW-1:0] GSTAT_ADDR = 7'h40;

  // field positions
  localparam int CTRL_IRQEN_BIT  = 0;
  localparam int CTRL_DOUBLE_BIT = 1;
  localparam int CTRL_RUN_BIT    = 2;
  localparam int OUTCTL_DIS_LSB  = 0;
  localparam int OUTCTL_XOVA_BIT = 4;
  localparam int OUTCTL_XOVB_BIT = 5;
  localparam int PIN_AH = 0;
  localparam int PIN_AL = 1;
  localparam int PIN_BH = 2;
  localparam int PIN_BL = 3;

  // reset values
  localparam logic [DW-1:0] REG_RST = 16'h0000;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b10
  } ppo_phase_t;
endpackage

/* File: core/ppo_cfg_if.sv */
`timescale 1ns/100ps
// ****************************************************************
// settings into one timing unit, pin levels and period start back
// ****************************************************************
interface ppo_cfg_if;
  logic                        run;
  logic                        dbl;
  logic [ppo_pkg::DW-1:0]      period;
  logic signed [ppo_pkg::DW-1:0] duty_a;
  logic signed [ppo_pkg::DW-1:0] duty_b;
  logic [ppo_pkg::DW-1:0]      dead;
  logic [3:0]                  dis;
  logic [1:0]                  xov;
  logic [3:0]                  pol;
  logic [3:0]                  pins;
  logic                        start;

  modport ctrl (output run, dbl, period, duty_a, duty_b, dead, dis, xov, pol,
                input pins, start);
  modport unit (input run, dbl, period, duty_a, duty_b, dead, dis, xov, pol,
                output pins, start);
endinterface

/* File: core/ppo_unit.sv */
`timescale 1ns/100ps
// ****************************************************************
// one center-aligned two-pair timing unit
// ****************************************************************
module ppo_unit #(
  parameter int DW = ppo_pkg::DW
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  ppo_cfg_if.unit   cfg
);
  ppo_pkg::ppo_phase_t st_r, st_nxt;
  logic [DW-1:0]        cnt_r, cnt_nxt, half_r, half_nxt;
  logic signed [DW-1:0] da_r, da_nxt, db_r, db_nxt;
  logic [DW-1:0]        dt_r, dt_nxt;
  logic [3:0]           dis_r, dis_nxt, pins_r, pins_nxt;
  logic [1:0]           xov_r, xov_nxt;
  logic                 start_r, start_nxt;
  logic                 load, at_end, running;
  logic [DW-1:0]        half_last, pos;
  logic signed [DW+1:0] sp, q, dx, dtx, thr_on, thr_off;
  logic [3:0]           on_v;
  logic                 h_on, l_on;

  // ****************************************************************
  // half-cycle sequencing and shadow loading
  // ****************************************************************
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    start_nxt = 1'b0;
    load      = 1'b0;
    half_last = half_r - 16'h0001;
    at_end    = (cnt_r >= half_last);
    case (st_r)
      ppo_pkg::PH_IDLE: begin
        if (cfg.run && (cfg.period[DW-1:1] != 15'h0000)) begin
          st_nxt    = ppo_pkg::PH_FIRST;
          cnt_nxt   = 16'h0000;
          load      = 1'b1;
          start_nxt = 1'b1;
        end
      end
      ppo_pkg::PH_FIRST: begin
        if (!cfg.run) begin
          st_nxt = ppo_pkg::PH_IDLE;
        end else if (at_end) begin
          st_nxt  = ppo_pkg::PH_SECOND;
          cnt_nxt = 16'h0000;
          load    = cfg.dbl;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ppo_pkg::PH_SECOND: begin
        if (!cfg.run) begin
          st_nxt = ppo_pkg::PH_IDLE;
        end else if (at_end) begin
          st_nxt    = ppo_pkg::PH_FIRST;
          cnt_nxt   = 16'h0000;
          load      = 1'b1;
          start_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: begin
        st_nxt = ppo_pkg::PH_IDLE;
      end
    endcase
    if (!cfg.run) begin
      cnt_nxt = 16'h0000;
    end
    // shadow copies only move at update points so a period stays coherent
    half_nxt = load ? {1'b0, cfg.period[DW-1:1]} : half_r;
    da_nxt   = load ? cfg.duty_a : da_r;
    db_nxt   = load ? cfg.duty_b : db_r;
    dt_nxt   = load ? cfg.dead : dt_r;
    dis_nxt  = load ? cfg.dis : dis_r;
    xov_nxt  = load ? cfg.xov : xov_r;
  end

  // ****************************************************************
  // edge placement, crossover, dead time, disable and polarity
  // ****************************************************************
  always_comb begin
    running = (st_r != ppo_pkg::PH_IDLE);
    pos     = (st_r == ppo_pkg::PH_SECOND) ? (half_last - cnt_r) : cnt_r;
    sp      = $signed({2'b00, pos});
    q       = $signed({3'b000, half_r[DW-1:1]});
    dtx     = $signed({2'b00, dt_r});
    on_v    = 4'h0;
    h_on    = 1'b0;
    l_on    = 1'b0;
    for (int k = 0; k < 2; k++) begin
      dx = (k == 0) ? {{2{da_r[DW-1]}}, da_r} : {{2{db_r[DW-1]}}, db_r};
      // both edges move off the duty instant by the dead time
      thr_on  = q - dx + dtx;
      thr_off = q - dx - dtx;
      h_on = (sp >= thr_on);
      l_on = (sp < thr_off);
      // the swapped pair keeps the gap, so shoot-through cover survives
      on_v[2*k]   = xov_r[k] ? l_on : h_on;
      on_v[2*k+1] = xov_r[k] ? h_on : l_on;
    end
    for (int i = 0; i < 4; i++) begin
      // polarity is live, a disabled pin sits at its off level
      pins_nxt[i] = (running && on_v[i] && !dis_r[i]) ? cfg.pol[i] : !cfg.pol[i];
    end
  end

  // registers only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= ppo_pkg::PH_IDLE;
      cnt_r   <= 16'h0000;
      half_r  <= 16'h0000;
      da_r    <= 16'h0000;
      db_r    <= 16'h0000;
      dt_r    <= 16'h0000;
      dis_r   <= 4'h0;
      xov_r   <= 2'h0;
      pins_r  <= 4'hF;
      start_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      half_r  <= half_nxt;
      da_r    <= da_nxt;
      db_r    <= db_nxt;
      dt_r    <= dt_nxt;
      dis_r   <= dis_nxt;
      xov_r   <= xov_nxt;
      pins_r  <= pins_nxt;
      start_r <= start_nxt;
    end
  end

  assign cfg.pins  = pins_r;
  assign cfg.start = start_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_dis_off;
    @(posedge clk_sys) disable iff (!rst_b)
      dis_r[0] |=> (pins_r[0] == !$past(cfg.pol[0]));
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("disabled pin not at off level");
  property p_dis_shadow;
    @(posedge clk_sys) disable iff (!rst_b)
      (dis_r != $past(dis_r)) |-> $past(load);
  endproperty
  a_dis_shadow: assert property (p_dis_shadow) else $error("disable moved off an update");
  property p_single_mid;
    @(posedge clk_sys) disable iff (!rst_b)
      (st_r == ppo_pkg::PH_FIRST && at_end && cfg.run && !cfg.dbl) |=> $stable(da_r);
  endproperty
  a_single_mid: assert property (p_single_mid) else $error("duty reloaded mid period");
  property p_double_mid;
    @(posedge clk_sys) disable iff (!rst_b)
      (st_r == ppo_pkg::PH_FIRST && at_end && cfg.run && cfg.dbl)
        |=> (da_r == $past(cfg.duty_a)) && (st_r == ppo_pkg::PH_SECOND);
  endproperty
  a_double_mid: assert property (p_double_mid) else $error("no mid period reload");
  property p_start_pos;
    @(posedge clk_sys) disable iff (!rst_b)
      start_r |-> (st_r == ppo_pkg::PH_FIRST) && (cnt_r == 16'h0000);
  endproperty
  a_start_pos: assert property (p_start_pos) else $error("period start misplaced");
  property p_idle_off;
    @(posedge clk_sys) disable iff (!rst_b)
      (st_r == ppo_pkg::PH_IDLE) |=> (pins_r == ~$past(cfg.pol));
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle pins not off");
endmodule

/* File: verification/ppo_switch_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// inverter switch bank hung on one unit's four pins
// ****************************************************************
module ppo_switch_model (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic [3:0]      pins,
  input  wire logic [3:0]      pol,
  input  wire logic            clr,
  output logic      [3:0][7:0] on_cnt,
  output logic                 shoot
);
  logic [3:0] on;

  // a switch conducts while its pin sits at the level its polarity names
  assign on = ~(pins ^ pol);

  // tally on-time per switch; latch a leg with both switches on, the case a real bridge burns in
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      on_cnt <= '0;
      shoot  <= 1'b0;
    end else if (clr) begin
      on_cnt <= '0;
      shoot  <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        on_cnt[i] <= on_cnt[i] + {7'h00, on[i]};
      end
      shoot <= shoot | (on[0] & on[1]) | (on[2] & on[3]);
    end
  end
endmodule

/* File: verification/ppo_paired_pwm_tb.sv */
`timescale 1ns/100ps
// ****************************************************************
// register-level bench for the paired pwm output stage
// ****************************************************************
module ppo_paired_pwm_tb;
  logic            clk_sys;
  logic            rst_b;
  logic            reg_wr;
  logic            reg_rd;
  logic            clr;
  logic            period_irq;
  logic            shoot;
  logic [6:0]      reg_addr;
  logic [15:0]     reg_wdata;
  logic [15:0]     reg_rdata;
  logic [3:0]      ah;
  logic [3:0]      al;
  logic [3:0]      bh;
  logic [3:0]      bl;
  logic [3:0]      pol_m;
  logic [3:0][7:0] on_cnt;
  int              num_errors;
  int              n_checks;
  int              k;

  ppo_paired_pwm ppo_paired_pwm_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_a_out(ah),
    .low_side_a_out(al), .high_side_b_out(bh), .low_side_b_out(bl),
    .period_irq(period_irq));

  ppo_switch_model ppo_switch_model_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .pins({bl[0], bh[0], al[0], ah[0]}),
    .pol(pol_m), .clr(clr), .on_cnt(on_cnt), .shoot(shoot));

  // 20 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobes; the trailing edge keeps back-to-back calls from double driving
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask

  // on cycles of one switch over two periods of eight clocks, q = 2, half = 4
  function automatic logic [15:0] f(input int x);
    return (x < 0) ? 16'h0000 : (x > 4) ? 16'h0010 : 16'(4 * x);
  endfunction

  task automatic run_row(input int da, input int db, input int dt, input logic [15:0] oc,
                         input logic [15:0] pl, input logic [15:0] ct);
    logic [3:0][15:0] e;
    wr(7'h02, 16'(da));
    wr(7'h03, 16'(db));
    wr(7'h04, 16'(dt));
    wr(7'h05, oc);
    wr(7'h06, pl);
    wr(7'h00, ct);
    pol_m <= pl[3:0];
    e[0] = f(2 + da - dt);
    e[1] = f(2 - da - dt);
    e[2] = f(2 + db - dt);
    e[3] = f(2 - db - dt);
    if (oc[4]) e[1:0] = {e[0], e[1]};
    if (oc[5]) e[3:2] = {e[2], e[3]};
    for (int i = 0; i < 4; i++) if (oc[i]) e[i] = 16'h0000;
    // shadowed settings land only at update points, so let three periods pass first
    repeat (24) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    for (int i = 0; i < 4; i++) chk({8'h00, on_cnt[i]}, e[i]);
    chk({15'h0000, shoot}, 16'h0000);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(50 * 20000);
    num_errors++;
    summarize();
  end

  initial begin
    rst_b      = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 7'h00;
    reg_wdata  = 16'h0000;
    clr        = 1'b0;
    pol_m      = 4'h0;
    num_errors = 0;
    n_checks   = 0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdchk(7'h00, 16'h0000);
    rdchk(7'h05, 16'h0000);
    wr(7'h07, 16'h0000);
    rdchk(7'h07, 16'h000F);
    rdchk(7'h48, 16'h0000);
    wr(7'h01, 16'h0008);
    run_row(0, 0, 0, 16'h0000, 16'h0000, 16'h0005);
    run_row(1, -1, 0, 16'h0000, 16'h0000, 16'h0005);
    run_row(-2, 3, 1, 16'h0000, 16'h0000, 16'h0005);
    run_row(4, -5, 1, 16'h0000, 16'h0000, 16'h0005);
    run_row(1, -1, 0, 16'h0001, 16'h0000, 16'h0005);
    run_row(1, -2, 0, 16'h0010, 16'h0000, 16'h0005);
    run_row(2, -1, 0, 16'h0020, 16'h0000, 16'h0005);
    run_row(1, -1, 0, 16'h000A, 16'h000F, 16'h0007);
    // clear stale status with the enable off; it must stay clear over two periods
    wr(7'h00, 16'h0004);
    wr(7'h40, 16'h0001);
    repeat (16) @(posedge clk_sys);
    rdchk(7'h40, 16'h0000);
    // enable again: the next period start sets the status and the line
    wr(7'h00, 16'h0005);
    for (k = 0; k < 20 && period_irq !== 1'b1; k++) @(negedge clk_sys);
    chk({15'h0000, period_irq}, 16'h0001);
    rdchk(7'h40, 16'h0001);
    wr(7'h00, 16'h0004);
    wr(7'h40, 16'h0001);
    repeat (16) @(posedge clk_sys);
    rdchk(7'h40, 16'h0000);
    chk({15'h0000, period_irq}, 16'h0000);
    // all outputs disabled: pins rest at the inverse of their polarity
    wr(7'h05, 16'h000F);
    wr(7'h06, 16'h0005);
    repeat (24) @(posedge clk_sys);
    rdchk(7'h07, 16'h000A);
    chk({ah, al, bh, bl}, 16'hEFEF);
    summarize();
  end
endmodule
